// >>> hw/bitclk_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "bitclk_defs.svh"

// Functional notes
// - Eight-bit interval counter runs from reset; software cannot halt it.
// - Counter advances once per prescaler pulse, ratios 8 to 1024 of oscillator.
// - Wrap from FF to 00 sets overflow flag, requesting the interval interrupt.
// - Writing clear bit zeroes counter; clear bit self-returns after one cycle.
// - Shared address reads count, writes control word; whole-byte writes only.
// - STOP with wake enable enters wake mode; only osc, /2048, timer0 run.
// - STOP with RC watchdog enable and wake enable clear enters RC mode; interval timer, watchdog run.
// - Watchdog select makes downstream counter a watchdog, else 7-bit timer.
// - Reset word clears both enables and clear bit, sets watchdog, slowest tap.
// - Oscillator passes a divide-by-two flop before internal clocking.
// - In RC oscillator mode, output pin drives oscillator divided by four.
// - RC oscillation selected only when configuration RC option bit is one.
module bitclk_top (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Oscillator and configuration
    input wire logic osc_i,
    input wire logic rc_osc_option_i,
    output logic xout_o,
    output logic xout_oe_o,
    output logic clk_phase_o,
    // Core power control
    input wire logic stop_req_i,
    input wire logic wake_i,
    input wire logic irq_ack_i,
    output bitclk_pkg::bitclk_mode_t power_mode_o,
    // Downstream timers
    output logic watchdog_select_o,
    output logic interval_tick_o,
    output logic wake_tick_o,
    // Interrupt
    output logic irq_o
);
    import bitclk_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    bitclk_tick_if tk ();

    bitclk_prescaler #(
        .PRE_W(`BITCLK_PRE_W)
    ) u_pre (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .osc_i(osc_i),
        .tk(tk.pre)
    );

    // Control word and state
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] interval_count_reg;
    logic [`BITCLK_IRQ_W-1:0] irq_status_reg;
    logic [`BITCLK_IRQ_W-1:0] irq_status_next;
    logic [`BITCLK_IRQ_W-1:0] irq_mask_reg;
    logic rc_option_reg;
    logic strap_done_reg;
    bitclk_mode_t mode_reg;
    bitclk_mode_t mode_next;
    logic interval_tick_reg;
    logic wake_tick_reg;
    logic xout_reg;

    // Bus state
    logic aw_held_reg;
    logic [7:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Field views
    wire wake_timer_enable = control_reg[`BITCLK_CW_WAKE_BIT];
    wire rc_watchdog_stop_enable = control_reg[`BITCLK_CW_RC_WATCHDOG_STOP_ENABLE_BIT];
    wire watchdog_select = control_reg[`BITCLK_CW_WDSEL_BIT];
    wire interval_clear = control_reg[`BITCLK_CW_CLEAR_BIT];
    wire [2:0] interval_clock_select = control_reg[`BITCLK_CW_SEL_MSB:`BITCLK_CW_SEL_LSB];

    // Write channel handshakes
    assign s_axi_awready_o = ~aw_held_reg;
    assign s_axi_wready_o = ~w_held_reg;
    wire aw_take = s_axi_awvalid_i & ~aw_held_reg;
    wire w_take = s_axi_wvalid_i & ~w_held_reg;
    wire wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;

    // Write decode
    wire wr_shared = wr_fire & (aw_addr_reg == `BITCLK_ADDR_SHARED);
    wire wr_status = wr_fire & (aw_addr_reg == `BITCLK_ADDR_IRQ_STATUS);
    wire wr_mask = wr_fire & (aw_addr_reg == `BITCLK_ADDR_IRQ_MASK);
    wire wr_mode = wr_fire & (aw_addr_reg == `BITCLK_ADDR_MODE_STATUS);
    wire wr_known = wr_shared | wr_status | wr_mask | wr_mode;
    // Control word takes whole bytes only
    wire ctl_load = wr_shared & w_strb_reg[0];
    wire [`BITCLK_IRQ_W-1:0] sw_clear = wr_status & w_strb_reg[0] ?
        w_data_reg[`BITCLK_IRQ_W-1:0] : '0;

    // Read decode
    assign s_axi_arready_o = ~rvalid_reg;
    wire ar_take = s_axi_arvalid_i & ~rvalid_reg;
    wire rd_shared = s_axi_araddr_i == `BITCLK_ADDR_SHARED;
    wire rd_status = s_axi_araddr_i == `BITCLK_ADDR_IRQ_STATUS;
    wire rd_mask = s_axi_araddr_i == `BITCLK_ADDR_IRQ_MASK;
    wire rd_mode = s_axi_araddr_i == `BITCLK_ADDR_MODE_STATUS;
    wire rd_known = rd_shared | rd_status | rd_mask | rd_mode;
    wire [31:0] mode_word = 32'({watchdog_select, rc_option_reg, 2'(mode_reg)});
    wire [31:0] rd_value = rd_shared ? 32'(interval_count_reg) :
        rd_status ? 32'(irq_status_reg) :
        rd_mask ? 32'(irq_mask_reg) :
        rd_mode ? mode_word : 32'h0000_0000;

    // Counting gates
    wire counting = (mode_reg == BITCLK_RUN) | (mode_reg == BITCLK_RC_WATCHDOG_STOP_ENABLE);
    wire count_step = tk.tap_tick & counting;
    wire overflow = count_step & ~interval_clear & (interval_count_reg == 8'hFF);
    wire wake_event = tk.tick_2048 & (mode_reg == BITCLK_WAKE);

    // Prescaler steering
    assign tk.sel = interval_clock_select;
    // Plain STOP halts the oscillator path entirely
    assign tk.run = mode_reg != BITCLK_STOP;

    always_comb begin
        control_next = control_reg;
        if (ctl_load) begin
            control_next = {1'b0, w_data_reg[6:0]};
        end else if (interval_clear) begin
            control_next[`BITCLK_CW_CLEAR_BIT] = 1'b0;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            BITCLK_RUN: begin
                if (stop_req_i) begin
                    // Wake enable wins when both enables are set
                    if (wake_timer_enable) begin
                        mode_next = BITCLK_WAKE;
                    end else if (rc_watchdog_stop_enable) begin
                        mode_next = BITCLK_RC_WATCHDOG_STOP_ENABLE;
                    end else begin
                        mode_next = BITCLK_STOP;
                    end
                end
            end
            BITCLK_STOP, BITCLK_WAKE, BITCLK_RC_WATCHDOG_STOP_ENABLE: begin
                if (wake_i) begin
                    mode_next = BITCLK_RUN;
                end
            end
            default: begin
                mode_next = BITCLK_RUN;
            end
        endcase
    end

    always_comb begin
        irq_status_next = irq_status_reg & ~sw_clear;
        if (irq_ack_i) begin
            irq_status_next[`BITCLK_IRQ_OVF_BIT] = 1'b0;
        end
        // Hardware set beats a clear in the same cycle
        if (overflow) begin
            irq_status_next[`BITCLK_IRQ_OVF_BIT] = 1'b1;
        end
        if (wake_event) begin
            irq_status_next[`BITCLK_IRQ_WAKE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            control_reg <= `BITCLK_CW_RESET;
            mode_reg <= BITCLK_RUN;
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
        end else begin
            control_reg <= control_next;
            mode_reg <= mode_next;
            irq_status_reg <= irq_status_next;
            if (wr_mask && w_strb_reg[0]) begin
                irq_mask_reg <= w_data_reg[`BITCLK_IRQ_W-1:0];
            end
        end
    end

    // No stop input exists for the counter by design
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            interval_count_reg <= 8'h00;
        end else if (interval_clear) begin
            interval_count_reg <= 8'h00;
        end else if (count_step) begin
            interval_count_reg <= interval_count_reg + 8'h01;
        end
    end

    // Strap caught once after reset release
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rc_option_reg <= 1'b0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            rc_option_reg <= rc_osc_option_i;
            strap_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            interval_tick_reg <= 1'b0;
            wake_tick_reg <= 1'b0;
            xout_reg <= 1'b0;
        end else begin
            // No tick for a step swallowed by a clear, so the tick follows the count
            interval_tick_reg <= count_step & ~interval_clear;
            wake_tick_reg <= wake_event;
            xout_reg <= tk.quarter & rc_option_reg;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr_i;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata_i;
                w_strb_reg <= s_axi_wstrb_i;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Outputs
    assign s_axi_bvalid_o = bvalid_reg;
    assign s_axi_bresp_o = bresp_reg;
    assign s_axi_rvalid_o = rvalid_reg;
    assign s_axi_rdata_o = rdata_reg;
    assign s_axi_rresp_o = rresp_reg;
    assign xout_o = xout_reg;
    assign xout_oe_o = rc_option_reg;
    assign clk_phase_o = tk.phase;
    assign power_mode_o = mode_reg;
    assign watchdog_select_o = watchdog_select;
    assign interval_tick_o = interval_tick_reg;
    assign wake_tick_o = wake_tick_reg;
    assign irq_o = |(irq_status_reg & irq_mask_reg);

endmodule : bitclk_top

// >>> hw/bitclk_defs.svh
`ifndef BITCLK_DEFS_SVH
`define BITCLK_DEFS_SVH

// Byte addresses on the register bus
`define BITCLK_ADDR_SHARED 8'hEC
`define BITCLK_ADDR_IRQ_STATUS 8'hF0
`define BITCLK_ADDR_IRQ_MASK 8'hF4
`define BITCLK_ADDR_MODE_STATUS 8'hF8

// Clock control word fields
`define BITCLK_CW_WAKE_BIT 6
`define BITCLK_CW_RC_WATCHDOG_STOP_ENABLE_BIT 5
`define BITCLK_CW_WDSEL_BIT 4
`define BITCLK_CW_CLEAR_BIT 3
`define BITCLK_CW_SEL_MSB 2
`define BITCLK_CW_SEL_LSB 0
`define BITCLK_CW_RESET 8'h17

// Interrupt status and mask fields
`define BITCLK_IRQ_OVF_BIT 0
`define BITCLK_IRQ_WAKE_BIT 1
`define BITCLK_IRQ_W 2

// Mode status fields
`define BITCLK_MS_MODE_LSB 0
`define BITCLK_MS_RC_OSC_OPTION_BIT 2
`define BITCLK_MS_WDSEL_BIT 3

// Timing
`define BITCLK_CLEAR_CYCLES 1
`define BITCLK_BASE_DIV_LOG2 2
`define BITCLK_PRE_W 10

`endif

// >>> hw/bitclk_pkg.sv
package bitclk_pkg;

    typedef enum logic [1:0] {
        BITCLK_RUN,
        BITCLK_STOP,
        BITCLK_WAKE,
        BITCLK_RC_WATCHDOG_STOP_ENABLE
    } bitclk_mode_t;

    typedef logic [2:0] bitclk_sel_t;

endpackage : bitclk_pkg

// >>> hw/bitclk_tick_if.sv
`timescale 1ns/1ps

interface bitclk_tick_if;
    import bitclk_pkg::*;

    bitclk_sel_t sel;
    logic run;
    logic phase;
    logic tap_tick;
    logic tick_2048;
    logic quarter;

    modport pre (
        input sel,
        input run,
        output phase,
        output tap_tick,
        output tick_2048,
        output quarter
    );

    modport core (
        output sel,
        output run,
        input phase,
        input tap_tick,
        input tick_2048,
        input quarter
    );

endinterface : bitclk_tick_if

// >>> hw/bitclk_prescaler.sv
`timescale 1ns/1ps
`include "bitclk_defs.svh"

module bitclk_prescaler #(
    parameter int PRE_W = `BITCLK_PRE_W
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Oscillator pin
    input wire logic osc_i,
    // Tap interface
    bitclk_tick_if.pre tk
);
    import bitclk_pkg::*;

    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic div2_reg;
    logic [PRE_W-1:0] pre_cnt_reg;
    logic tap_tick_reg;
    logic tick_2048_reg;
    logic quarter_reg;

    wire osc_rise = osc_s2_reg & ~osc_s3_reg;
    // Every second rising oscillator edge, so input duty cycle does not matter
    wire half_tick = osc_rise & div2_reg & tk.run;
    wire [PRE_W-1:0] all_ones = {PRE_W{1'b1}};
    wire [3:0] sel_bits = 4'(tk.sel) + 4'(`BITCLK_BASE_DIV_LOG2);
    wire [PRE_W-1:0] tap_mask = ~(all_ones << sel_bits);
    wire tap_hit = half_tick & ((pre_cnt_reg & tap_mask) == tap_mask);
    wire full_hit = half_tick & (pre_cnt_reg == all_ones);

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            osc_s1_reg <= 1'b0;
            osc_s2_reg <= 1'b0;
            osc_s3_reg <= 1'b0;
        end else begin
            osc_s1_reg <= osc_i;
            osc_s2_reg <= osc_s1_reg;
            osc_s3_reg <= osc_s2_reg;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div2_reg <= 1'b0;
            pre_cnt_reg <= '0;
            tap_tick_reg <= 1'b0;
            tick_2048_reg <= 1'b0;
            quarter_reg <= 1'b0;
        end else begin
            if (osc_rise && tk.run) begin
                div2_reg <= ~div2_reg;
            end
            if (half_tick) begin
                pre_cnt_reg <= pre_cnt_reg + 1'b1;
            end
            tap_tick_reg <= tap_hit;
            tick_2048_reg <= full_hit;
            quarter_reg <= pre_cnt_reg[0];
        end
    end

    assign tk.phase = div2_reg;
    assign tk.tap_tick = tap_tick_reg;
    assign tk.tick_2048 = tick_2048_reg;
    assign tk.quarter = quarter_reg;

endmodule : bitclk_prescaler

// >>> bench/bitclk_props.sv
`timescale 1ns/1ps
module bitclk_props (
    // Clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Bus handshakes
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    // Core and timers
    input wire logic stop_req_i,
    input wire logic wake_i,
    input wire logic irq_ack_i,
    input wire bitclk_pkg::bitclk_mode_t power_mode_o,
    input wire logic watchdog_select_o,
    input wire logic interval_tick_o,
    input wire logic wake_tick_o,
    input wire logic irq_o
);
    import bitclk_pkg::*;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    chk_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
        else $error("write response dropped");
    chk_read_refuse: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken while busy");
    chk_wdsel_reset: assert property ($rose(arst_n_i) |-> watchdog_select_o)
        else $error("watchdog select not set");
    chk_tick_pulse: assert property (interval_tick_o |=> !interval_tick_o)
        else $error("tick too long");
    // Two settled cycles, since the tick lags its count step
    chk_tick_halt: assert property (power_mode_o inside {BITCLK_STOP, BITCLK_WAKE}
        && $stable(power_mode_o) && $past(power_mode_o, 2) == power_mode_o
        |-> !interval_tick_o) else $error("count moved while halted");
    chk_wake_tick: assert property (wake_tick_o |-> $past(power_mode_o) == BITCLK_WAKE)
        else $error("wake tick outside wake mode");
    chk_mode_enter: assert property ($changed(power_mode_o)
        && power_mode_o != BITCLK_RUN |-> $past(stop_req_i)
        && $past(power_mode_o) == BITCLK_RUN) else $error("stop mode without stop");
    chk_mode_exit: assert property ($changed(power_mode_o)
        && power_mode_o == BITCLK_RUN |-> $past(wake_i)) else $error("run without wake");
    chk_irq_sticky: assert property ($fell(irq_o)
        |-> $past(irq_ack_i) || $past(s_axi_wvalid_i, 2)) else $error("irq fell by itself");
    cov_irq: cover property (irq_o);
    cov_rc_watchdog_stop_enable: cover property (power_mode_o == BITCLK_RC_WATCHDOG_STOP_ENABLE);
    cov_wake_tick: cover property (wake_tick_o);
endmodule : bitclk_props

bind bitclk_top bitclk_props u_props (.*);

// >>> bench/basic_interval_timer_clkctl_tb.sv
`timescale 1ns/1ps
module basic_interval_timer_clkctl_tb;
    import bitclk_pkg::*;
    logic clock_i = 1'h0;
    logic arst_n_i = 1'h0;
    logic [7:0] s_axi_awaddr_i = 8'h0, s_axi_araddr_i = 8'h0;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
    logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, osc_i = 1'h0;
    logic rc_osc_option_i = 1'h1, stop_req_i = 1'h0, wake_i = 1'h0, irq_ack_i = 1'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rsp, oc = 2'h0;
    logic xout_o, xout_oe_o, clk_phase_o, watchdog_select_o, interval_tick_o, wake_tick_o, irq_o;
    bitclk_mode_t power_mode_o;
    int error_cnt = 0, comparisons = 0, cyc = 0, n;

    bitclk_top uut (.*);

    always #12.5 clock_i = ~clock_i;

    // Oscillator at a quarter of the clock, above the synchroniser minimum
    always @(posedge clock_i) begin
        oc <= oc + 2'h1;
        osc_i <= oc[1];
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do begin
            @(posedge clock_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
        end while (s_axi_bvalid_o !== 1'h1);
        rsp = s_axi_bresp_o;
        s_axi_bready_i <= 1'h0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do begin
            @(posedge clock_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
        end while (s_axi_rvalid_o !== 1'h1);
        rd = s_axi_rdata_o;
        rsp = s_axi_rresp_o;
        s_axi_rready_i <= 1'h0;
    endtask : rdr

    task automatic tk(input int k);
        repeat (k) begin
            do @(posedge clock_i); while (interval_tick_o !== 1'h1);
        end
    endtask : tk

    // Cycles between two rising edges of the chosen output
    task automatic meas(input int w);
        int k;
        logic p;
        k = 0;
        p = 1'h1;
        while (k < 2) begin
            @(posedge clock_i);
            n++;
            if (p === 1'h0 && (w == 0 ? interval_tick_o : w == 1 ? xout_o : clk_phase_o)) begin
                if (k == 0) n = 0;
                k++;
            end
            p = w == 0 ? interval_tick_o : w == 1 ? xout_o : clk_phase_o;
        end
    endtask : meas

    task automatic t_rst();
        rdr(8'hF8);
        chk("mode status", 32'hC, rd);
        chk("read response", 32'h0, rsp);
        s_axi_wstrb_i <= 4'h0;
        wr(8'hEC, 32'h0);
        s_axi_wstrb_i <= 4'hF;
        chk("write response", 32'h0, rsp);
        chk("partial write", 32'h1, watchdog_select_o);
        wr(8'h10, 32'h0);
        chk("unmapped write", 32'h2, rsp);
        rdr(8'h10);
        chk("unmapped read", 32'h2, rsp);
    endtask : t_rst

    // Bit 7 set as well, it must be ignored
    task automatic t_sel();
        for (int s = 0; s < 8; s++) begin
            wr(8'hEC, 32'h80 | (s[0] ? 32'h0 : 32'h10) | s);
            meas(0);
            chk("tick spacing", 32 << s, n);
            chk("watchdog select", !s[0], watchdog_select_o);
        end
        // Second reset with the watchdog select cleared
        arst_n_i <= 1'h0;
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'h1;
        rdr(8'hF8);
        chk("mode after reset", 32'hC, rd);
    endtask : t_sel

    task automatic t_clr();
        wr(8'hEC, 32'h18);
        tk(1);
        rdr(8'hEC);
        chk("count after clear", 32'h1, rd[7:0]);
        tk(4);
        rdr(8'hEC);
        chk("count running", 32'h5, rd[7:0]);
    endtask : t_clr

    task automatic t_ovf();
        wr(8'hF4, 32'h1);
        wr(8'hF0, 32'h3);
        do @(posedge clock_i); while (irq_o !== 1'h1);
        rdr(8'hEC);
        chk("count at wrap", 32'h0, rd[7:0]);
        tk(2);
        rdr(8'hF0);
        chk("status sticky", 32'h1, rd);
        wr(8'hF4, 32'h0);
        chk("masked irq", 32'h0, irq_o);
        wr(8'hF4, 32'h1);
        chk("unmasked irq", 32'h1, irq_o);
        wr(8'hF0, 32'h1);
        chk("cleared irq", 32'h0, irq_o);
        do @(posedge clock_i); while (irq_o !== 1'h1);
        irq_ack_i <= 1'h1;
        @(posedge clock_i) irq_ack_i <= 1'h0;
        @(posedge clock_i);
        chk("acked irq", 32'h0, irq_o);
    endtask : t_ovf

    // Both enables set: wake timer takes precedence
    task automatic t_mode();
        bitclk_mode_t m [4] = '{BITCLK_WAKE, BITCLK_RC_WATCHDOG_STOP_ENABLE, BITCLK_STOP, BITCLK_WAKE};
        logic [7:0] w [4] = '{8'h50, 8'h30, 8'h10, 8'h70};
        logic [7:0] a;
        for (int i = 0; i < 4; i++) begin
            wr(8'hEC, {24'h0, w[i]});
            @(posedge clock_i) stop_req_i <= 1'h1;
            @(posedge clock_i) stop_req_i <= 1'h0;
            @(posedge clock_i);
            chk("power mode", m[i], power_mode_o);
            rdr(8'hEC);
            a = rd[7:0];
            repeat (100) @(posedge clock_i);
            rdr(8'hEC);
            chk("count moved", m[i] == BITCLK_RC_WATCHDOG_STOP_ENABLE, rd[7:0] != a);
            if (i == 0) begin
                do @(posedge clock_i); while (wake_tick_o !== 1'h1);
                rdr(8'hF0);
                chk("wake flag", 32'h1, rd[1]);
            end
            @(posedge clock_i) wake_i <= 1'h1;
            @(posedge clock_i) wake_i <= 1'h0;
            @(posedge clock_i);
            chk("back to run", BITCLK_RUN, power_mode_o);
        end
    endtask : t_mode

    task automatic t_osc();
        chk("xout enable", 32'h1, xout_oe_o);
        meas(1);
        chk("xout period", 32'h10, n);
        meas(2);
        chk("phase period", 32'h8, n);
    endtask : t_osc

    initial begin
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'h1;
        t_rst();
        $display("reset test done");
        t_sel();
        $display("select test done");
        t_clr();
        $display("clear test done");
        t_ovf();
        $display("overflow test done");
        t_mode();
        $display("mode test done");
        t_osc();
        $display("oscillator test done");
        finish_test();
    end
endmodule : basic_interval_timer_clkctl_tb
